// ### src/dual_pll_config_register_bank.sv
// loop configuration register bank behind the serial control pins
`timescale 1ns/1ps
`include "pll_cfg_defs.svh"

// Behaviour
// - first lock after window held for programmed count, default 1024
// - second lock after window held for programmed count, default 8192
// - two-bit first lock window, reset code 3 is 40 ns
// - dac update tick divides first detector rate by ten-bit divisor, reset 4
// - doubler bit doubles second reference, clear at reset
// - second pump polarity negative, tristate active, at reset
// - three input predividers, divide 1/2/4/8, reset divide-by-1
// - first reference divider, 14 bits, 1..16383, reset 96
// - first feedback divider, 14 bits, 1..16383, reset 192
// - second reference divider, 12 bits, 1..4095, reset 4
// - second feedback divider, 18 bits, 1..262143, reset 48
// - three-bit second prescaler, divide 2..8, reset 2
// - detector above 100 MHz only while fast bit set, set at reset
// - five-bit readback address picks register, reset 31
// - lock bit in register 31 blocks writes to registers 0..30
// - first feedback and reference delays, three bits, reset zero
// - registers 0..5 each control one even/odd output pair, same layout
// - soft reset only in register 0, powerdown only in register 1
// - oscillator source select bit only in registers 3 and 4
// - reset bit reloads defaults, clears on another register write
module dual_pll_config_register_bank
(
   input  wire logic        i_core_clk,
   input  wire logic        i_sys_rst,
   // serial control pins
   input  wire logic        i_ser_clk,
   input  wire logic        i_ser_data,
   input  wire logic        i_serial_latch_enable,
   output logic             o_readback_data,
   // lock detector inputs from the phase detectors
   input  wire logic        i_first_pd_tick,
   input  wire logic        i_first_in_window,
   input  wire logic        i_second_pd_tick,
   input  wire logic        i_second_in_window,
   // lock and tuning outputs
   output logic             o_first_lock_indicator,
   output logic             o_second_lock_indicator,
   output logic             o_dac_update,
   // output group configuration
   output logic [5:0][31:0] o_group_cfg,
   output logic             o_soft_reset_pending,
   output logic             o_powerdown,
   // loop configuration fields
   output logic [2:0]       o_first_loop_feedback_delay,
   output logic [2:0]       o_first_loop_reference_delay,
   output logic [1:0]       o_first_loop_lock_window,
   output logic [9:0]       o_dac_divisor,
   output logic [13:0]      o_first_loop_lock_count,
   output logic [1:0]       o_second_loop_lock_window,
   output logic             o_reference_doubler_enable,
   output logic             o_second_loop_pump_polarity,
   output logic             o_second_loop_pump_tristate,
   output logic [13:0]      o_second_loop_lock_count,
   output logic [1:0]       o_input0_predivider,
   output logic [1:0]       o_input1_predivider,
   output logic [1:0]       o_input2_predivider,
   output logic [13:0]      o_first_loop_ref_divider,
   output logic [11:0]      o_second_loop_ref_divider,
   output logic [13:0]      o_first_loop_feedback_divider,
   output logic [2:0]       o_oscillator_input_range,
   output logic             o_fast_detector_allow,
   output logic [17:0]      o_calibration_feedback_copy,
   output logic [2:0]       o_second_loop_prescaler,
   output logic [17:0]      o_second_loop_feedback_divider,
   output logic             o_readback_latch_level,
   output logic [4:0]       o_readback_address,
   output logic             o_register_write_lock
);
   localparam pll_cfg_pkg::slot_t S_LOOP_FILTER = 4'h6;
   localparam pll_cfg_pkg::slot_t S_TUNING_DAC  = 4'h7;
   localparam pll_cfg_pkg::slot_t S_SECOND_DET  = 4'h8;
   localparam pll_cfg_pkg::slot_t S_FIRST_PUMP  = 4'h9;
   localparam pll_cfg_pkg::slot_t S_REF_DIV_B   = 4'hA;
   localparam pll_cfg_pkg::slot_t S_OSC_RANGE   = 4'hB;
   localparam pll_cfg_pkg::slot_t S_SECOND_FB   = 4'hC;
   localparam pll_cfg_pkg::slot_t S_READBACK    = 4'hD;

   pll_cfg_pkg::bank_state_s st;
   pll_cfg_pkg::bank_state_s next_st;
   pll_cfg_pkg::word_t       rx_word;
   logic                     rx_valid;
   logic                     rx_fall;
   logic                     first_locked;
   logic                     second_locked;
   logic                     first_lock_q;
   logic                     second_lock_q;

   // only registers 0..5 and 24..31 hold storage
   function automatic logic is_stored(input logic [4:0] addr);
      return (addr <= `REG_GROUP_LAST) || (addr >= `REG_LOOP_FILTER);
   endfunction

   function automatic pll_cfg_pkg::slot_t slot_of(input logic [4:0] addr);
      logic [4:0] s;
      s = (addr <= `REG_GROUP_LAST) ? addr : (addr - `SLOT_HIGH_BASE);
      return s[3:0];
   endfunction

   function automatic logic [4:0] addr_of(input pll_cfg_pkg::slot_t s);
      logic [4:0] a;
      a = {1'b0, s};
      return (s < 4'h6) ? a : (a + `SLOT_HIGH_BASE);
   endfunction

   // writable bits; single-register group bits only where they exist
   function automatic pll_cfg_pkg::word_t mask_of(input logic [4:0] addr);
      pll_cfg_pkg::word_t m;
      m = '0;
      case (addr)
         5'h00:                m = `MASK_GROUP_COMMON | `MASK_GROUP_BIT17;
         5'h01:                m = `MASK_GROUP_COMMON | `MASK_GROUP_BIT17;
         5'h02:                m = `MASK_GROUP_COMMON;
         5'h03:                m = `MASK_GROUP_COMMON | `MASK_GROUP_BIT30;
         5'h04:                m = `MASK_GROUP_COMMON | `MASK_GROUP_BIT30;
         5'h05:                m = `MASK_GROUP_COMMON;
         `REG_LOOP_FILTER:     m = `MASK_LOOP_FILTER;
         `REG_TUNING_DAC:      m = `MASK_TUNING_DAC;
         `REG_SECOND_DETECTOR: m = `MASK_SECOND_DETECTOR;
         `REG_FIRST_PUMP:      m = `MASK_FIRST_PUMP;
         `REG_REF_DIV_B:       m = `MASK_REF_DIV_B;
         `REG_OSC_RANGE:       m = `MASK_OSC_RANGE;
         `REG_SECOND_FEEDBACK: m = `MASK_SECOND_FEEDBACK;
         `REG_READBACK_LOCK:   m = `MASK_READBACK_LOCK;
         default:              m = '0;
      endcase
      return m;
   endfunction

   // silicon default per register
   function automatic pll_cfg_pkg::word_t default_of(input logic [4:0] addr);
      pll_cfg_pkg::word_t d;
      d = '0;
      case (addr)
         `REG_LOOP_FILTER:     d = `RST_LOOP_FILTER;
         `REG_TUNING_DAC:      d = `RST_TUNING_DAC;
         `REG_SECOND_DETECTOR: d = `RST_SECOND_DETECTOR;
         `REG_FIRST_PUMP:      d = `RST_FIRST_PUMP;
         `REG_REF_DIV_B:       d = `RST_REF_DIV_B;
         `REG_OSC_RANGE:       d = `RST_OSC_RANGE;
         `REG_SECOND_FEEDBACK: d = `RST_SECOND_FEEDBACK;
         `REG_READBACK_LOCK:   d = `RST_READBACK_LOCK;
         default:              d = `RST_GROUP;
      endcase
      return d;
   endfunction

   function automatic logic [13:0][31:0] all_defaults();
      logic [13:0][31:0] r;
      r = '0;
      for (int i = 0; i < `SLOT_COUNT; i++)
      begin
         r[i] = default_of(addr_of(4'(i)));
      end
      return r;
   endfunction

   serial_word_receiver u_rx
   (
      .i_core_clk   (i_core_clk),
      .i_sys_rst    (i_sys_rst),
      .i_ser_clk    (i_ser_clk),
      .i_ser_data   (i_ser_data),
      .i_ser_le     (i_serial_latch_enable),
      .o_word       (rx_word),
      .o_word_valid (rx_valid),
      .o_clk_fall   (rx_fall)
   );

   lock_detector #(.WIDTH(`LOCK_COUNT_WIDTH)) u_first_lock
   (
      .i_core_clk  (i_core_clk),
      .i_sys_rst   (i_sys_rst),
      .i_pd_tick   (i_first_pd_tick),
      .i_in_window (i_first_in_window),
      .i_threshold (st.regs[S_TUNING_DAC][19:6]),
      .o_locked    (first_locked)
   );

   lock_detector #(.WIDTH(`LOCK_COUNT_WIDTH)) u_second_lock
   (
      .i_core_clk  (i_core_clk),
      .i_sys_rst   (i_sys_rst),
      .i_pd_tick   (i_second_pd_tick),
      .i_in_window (i_second_in_window),
      .i_threshold (st.regs[S_SECOND_DET][19:6]),
      .o_locked    (second_locked)
   );

   // writes, soft reset, dac divider and readback shifter
   always_comb
   begin
      logic [4:0]          addr;
      pll_cfg_pkg::slot_t  s;
      pll_cfg_pkg::word_t  m;
      logic [9:0]          div;
      logic [4:0]          rb_addr;
      addr          = rx_word[`ADDR_MSB:`ADDR_LSB];
      s             = slot_of(addr);
      m             = mask_of(addr);
      div = (st.regs[S_TUNING_DAC][31:22] == '0) ? 10'h001 : st.regs[S_TUNING_DAC][31:22];
      rb_addr       = 5'h00;
      next_st       = st;
      next_st.dac_tick = 1'b0;

      // one dac tick per divisor detector ticks
      if (i_first_pd_tick)
      begin
         if ((st.dac_cnt + 10'h001) >= div)
         begin
            next_st.dac_cnt  = 10'h000;
            next_st.dac_tick = 1'b1;
         end
         else
         begin
            next_st.dac_cnt = st.dac_cnt + 10'h001;
         end
      end

      // locked writes are dropped silently; register 31 stays writable to unlock
      if (rx_valid && ((addr == `REG_READBACK_LOCK) || !st.regs[S_READBACK][5]))
      begin
         if ((addr == 5'h00) && rx_word[`GROUP_SOFT_RESET_BIT])
         begin
            // rest of the word is ignored; flag stays visible until next write
            next_st.regs = all_defaults();
            next_st.regs[0][`GROUP_SOFT_RESET_BIT] = 1'b1;
            next_st.dac_cnt = 10'h000;
         end
         else
         begin
            if (addr != 5'h00)
            begin
               next_st.regs[0][`GROUP_SOFT_RESET_BIT] = 1'b0;
            end
            if (is_stored(addr))
            begin
               next_st.regs[s] = (st.regs[s] & ~m) | (rx_word & m);
            end
         end
      end

      // every received word reloads the shifter, dropped locked writes included
      if (rx_valid)
      begin
         rb_addr = next_st.regs[S_READBACK][20:16];
         if (is_stored(rb_addr))
         begin
            next_st.rb_shift = next_st.regs[slot_of(rb_addr)] | {27'h0, rb_addr};
         end
         else
         begin
            next_st.rb_shift = {27'h0, rb_addr};
         end
      end
      else if (rx_fall)
      begin
         next_st.rb_shift = {st.rb_shift[30:0], 1'b0};
      end
   end

   // state register
   always_ff @(posedge i_core_clk)
   begin
      if (i_sys_rst)
      begin
         st.regs     <= all_defaults();
         st.dac_cnt  <= '0;
         st.dac_tick <= 1'b0;
         st.rb_shift <= '0;
      end
      else
      begin
         st <= next_st;
      end
   end

   // lock indicators retimed into top flops
   always_ff @(posedge i_core_clk)
   begin
      if (i_sys_rst)
      begin
         first_lock_q  <= 1'b0;
         second_lock_q <= 1'b0;
      end
      else
      begin
         first_lock_q  <= first_locked;
         second_lock_q <= second_locked;
      end
   end

   assign o_first_lock_indicator  = first_lock_q;
   assign o_second_lock_indicator = second_lock_q;
   assign o_dac_update            = st.dac_tick;
   assign o_readback_data         = st.rb_shift[31];

   // field views straight off the stored words
   assign o_group_cfg                    = st.regs[5:0];
   assign o_soft_reset_pending           = st.regs[0][`GROUP_SOFT_RESET_BIT];
   assign o_powerdown                    = st.regs[1][`GROUP_POWERDOWN_BIT];
   assign o_first_loop_feedback_delay    = st.regs[S_LOOP_FILTER][14:12];
   assign o_first_loop_reference_delay   = st.regs[S_LOOP_FILTER][10:8];
   assign o_first_loop_lock_window       = st.regs[S_LOOP_FILTER][7:6];
   assign o_dac_divisor                  = st.regs[S_TUNING_DAC][31:22];
   assign o_first_loop_lock_count        = st.regs[S_TUNING_DAC][19:6];
   assign o_second_loop_lock_window      = st.regs[S_SECOND_DET][31:30];
   assign o_reference_doubler_enable     = st.regs[S_SECOND_DET][29];
   assign o_second_loop_pump_polarity    = st.regs[S_SECOND_DET][28];
   assign o_second_loop_pump_tristate    = st.regs[S_SECOND_DET][5];
   assign o_second_loop_lock_count       = st.regs[S_SECOND_DET][19:6];
   assign o_input2_predivider            = st.regs[S_FIRST_PUMP][25:24];
   assign o_input1_predivider            = st.regs[S_FIRST_PUMP][23:22];
   assign o_input0_predivider            = st.regs[S_FIRST_PUMP][21:20];
   assign o_first_loop_ref_divider       = st.regs[S_FIRST_PUMP][19:6];
   assign o_second_loop_ref_divider      = st.regs[S_REF_DIV_B][31:20];
   assign o_first_loop_feedback_divider  = st.regs[S_REF_DIV_B][19:6];
   assign o_oscillator_input_range       = st.regs[S_OSC_RANGE][26:24];
   assign o_fast_detector_allow          = st.regs[S_OSC_RANGE][23];
   assign o_calibration_feedback_copy    = st.regs[S_OSC_RANGE][22:5];
   assign o_second_loop_prescaler        = st.regs[S_SECOND_FB][26:24];
   assign o_second_loop_feedback_divider = st.regs[S_SECOND_FB][22:5];
   assign o_readback_latch_level         = st.regs[S_READBACK][21];
   assign o_readback_address             = st.regs[S_READBACK][20:16];
   assign o_register_write_lock          = st.regs[S_READBACK][5];
endmodule

// ### inc/pll_cfg_defs.svh
// offsets, field bits, write masks and reset values of the loop bank
`ifndef PLL_CFG_DEFS_SVH
`define PLL_CFG_DEFS_SVH

// register numbers carried in the low five bits of each serial word
`define ADDR_LSB               0
`define ADDR_MSB               4
`define REG_GROUP_LAST         5'h05
`define REG_LOOP_FILTER        5'h18
`define REG_TUNING_DAC         5'h19
`define REG_SECOND_DETECTOR    5'h1A
`define REG_FIRST_PUMP         5'h1B
`define REG_REF_DIV_B          5'h1C
`define REG_OSC_RANGE          5'h1D
`define REG_SECOND_FEEDBACK    5'h1E
`define REG_READBACK_LOCK      5'h1F
`define SLOT_COUNT             14
`define SLOT_HIGH_BASE         5'h12

// output group field positions
`define GROUP_SOFT_RESET_BIT   17
`define GROUP_POWERDOWN_BIT    17

// writable bits; address bits never store
`define MASK_GROUP_COMMON      32'hBFFD_FFE0
`define MASK_GROUP_BIT17       32'h0002_0000
`define MASK_GROUP_BIT30       32'h4000_0000
`define MASK_LOOP_FILTER       32'hFF77_77C0
`define MASK_TUNING_DAC        32'hFFCF_FFC0
`define MASK_SECOND_DETECTOR   32'hFC0F_FFE0
`define MASK_FIRST_PUMP        32'h1FFF_FFE0
`define MASK_REF_DIV_B         32'hFFFF_FFC0
`define MASK_OSC_RANGE         32'h07FF_FFE0
`define MASK_SECOND_FEEDBACK   32'h077F_FFE0
`define MASK_READBACK_LOCK     32'h003F_0020

// reset values from the field defaults
`define RST_GROUP              32'h0000_0000
`define RST_LOOP_FILTER        32'h0000_00C0
`define RST_TUNING_DAC         32'h0101_0000
`define RST_SECOND_DETECTOR    32'h0C08_0000
`define RST_FIRST_PUMP         32'h1000_1800
`define RST_REF_DIV_B          32'h0040_3000
`define RST_OSC_RANGE          32'h0780_0600
`define RST_SECOND_FEEDBACK    32'h0200_0600
`define RST_READBACK_LOCK      32'h001F_0000

// lock detector count width
`define LOCK_COUNT_WIDTH       14

`endif

// ### inc/pll_cfg_pkg.sv
// shared types of the loop configuration bank
package pll_cfg_pkg;
   typedef logic [31:0] word_t;
   typedef logic [3:0]  slot_t;

   // bank state: words, dac divider, readback shifter
   typedef struct packed {
      logic [13:0][31:0] regs;
      logic [9:0]        dac_cnt;
      logic              dac_tick;
      logic [31:0]       rb_shift;
   } bank_state_s;

   // serial receiver state
   typedef struct packed {
      logic        clk_d;
      logic        le_d;
      logic [31:0] shift;
      logic [31:0] word;
      logic        valid;
      logic        fall;
   } rx_state_s;
endpackage

// ### src/serial_word_receiver.sv
// serial word receiver: shift on clock rise, word on latch rise
`timescale 1ns/1ps
module serial_word_receiver
(
   input  wire logic        i_core_clk,
   input  wire logic        i_sys_rst,
   input  wire logic        i_ser_clk,
   input  wire logic        i_ser_data,
   input  wire logic        i_ser_le,
   output logic [31:0]      o_word,
   output logic             o_word_valid,
   output logic             o_clk_fall
);
   pll_cfg_pkg::rx_state_s st;
   pll_cfg_pkg::rx_state_s next_st;

   // edge detection on the sampled pins; pins are already synchronous
   always_comb
   begin
      next_st       = st;
      next_st.clk_d = i_ser_clk;
      next_st.le_d  = i_ser_le;
      next_st.valid = 1'b0;
      next_st.fall  = st.clk_d & ~i_ser_clk;
      if (i_ser_clk & ~st.clk_d & ~i_ser_le)
      begin
         next_st.shift = {st.shift[30:0], i_ser_data}; // msb first
      end
      if (i_ser_le & ~st.le_d)
      begin
         next_st.word  = st.shift;
         next_st.valid = 1'b1;
      end
   end

   always_ff @(posedge i_core_clk)
   begin
      if (i_sys_rst)
      begin
         st <= '0;
      end
      else
      begin
         st <= next_st;
      end
   end

   assign o_word       = st.word;
   assign o_word_valid = st.valid;
   assign o_clk_fall   = st.fall;
endmodule

// ### src/lock_detector.sv
// digital lock detector: counts detector cycles spent inside the window
`timescale 1ns/1ps
module lock_detector
#(
   parameter int WIDTH = 14
)
(
   input  wire logic             i_core_clk,
   input  wire logic             i_sys_rst,
   input  wire logic             i_pd_tick,
   input  wire logic             i_in_window,
   input  wire logic [WIDTH-1:0] i_threshold,
   output logic                  o_locked
);
   typedef struct packed {
      logic [WIDTH-1:0] count;
      logic             locked;
   } lock_state_s;

   lock_state_s      st;
   lock_state_s      next_st;
   logic [WIDTH-1:0] thr;

   // a zero threshold would lock at once; treat it as one cycle
   assign thr = (i_threshold == '0) ? WIDTH'(1) : i_threshold;

   // any cycle outside the window restarts the count and drops lock
   always_comb
   begin
      next_st = st;
      if (i_pd_tick)
      begin
         if (!i_in_window)
         begin
            next_st.count  = '0;
            next_st.locked = 1'b0;
         end
         else if (st.count < thr)
         begin
            next_st.count  = st.count + WIDTH'(1);
            next_st.locked = ((st.count + WIDTH'(1)) >= thr);
         end
         else
         begin
            next_st.locked = 1'b1;
         end
      end
   end

   always_ff @(posedge i_core_clk)
   begin
      if (i_sys_rst)
      begin
         st <= '0;
      end
      else
      begin
         st <= next_st;
      end
   end

   assign o_locked = st.locked;
endmodule

// ### verification/host_serial_model.sv
// host controller model that drives the serial control pins
`timescale 1ns/1ps
module host_serial_model
(
   input  wire logic i_core_clk,
   output logic      o_ser_clk,
   output logic      o_ser_data,
   output logic      o_latch
);
   // clock parked low, latch low for readback level 0
   initial
   begin
      o_ser_clk  = 1'b0;
      o_ser_data = 1'b0;
      o_latch    = 1'b0;
   end

   // msb first, each clock level held two core cycles, each data bit four
   task automatic send(input logic [31:0] w);
      for (int i = 31; i >= 0; i--)
      begin
         o_ser_data = w[i];
         o_ser_clk  = 1'b0;
         repeat (2) @(posedge i_core_clk);
         #1 o_ser_clk = 1'b1;
         repeat (2) @(posedge i_core_clk);
         #1;
      end
      // released data shows the inverse, not a stale bit
      o_ser_clk  = 1'b0;
      o_ser_data = ~o_ser_data;
      repeat (2) @(posedge i_core_clk);
      #1 o_latch = 1'b1;
      repeat (2) @(posedge i_core_clk);
      #1 o_latch = 1'b0;
      repeat (4) @(posedge i_core_clk);
      #1;
   endtask
endmodule

// ### verification/dual_pll_config_register_bank_chk.sv
// concurrent checks on the loop configuration bank ports
`timescale 1ns/1ps
module dual_pll_config_register_bank_chk
(
   input wire logic             i_core_clk,
   input wire logic             i_sys_rst,
   input wire logic             i_serial_latch_enable,
   input wire logic             i_first_pd_tick,
   input wire logic             i_first_in_window,
   input wire logic             i_second_pd_tick,
   input wire logic             i_second_in_window,
   input wire logic             o_first_lock_indicator,
   input wire logic             o_second_lock_indicator,
   input wire logic             o_dac_update,
   input wire logic [5:0][31:0] o_group_cfg,
   input wire logic             o_soft_reset_pending,
   input wire logic             o_powerdown,
   input wire logic [13:0]      o_first_loop_ref_divider,
   input wire logic [17:0]      o_second_loop_feedback_divider,
   input wire logic [4:0]       o_readback_address,
   input wire logic             o_register_write_lock
);
   default clocking @(posedge i_core_clk); endclocking
   default disable iff (i_sys_rst);

   // in-window first tick
   logic hit1;
   assign hit1 = i_first_pd_tick && i_first_in_window;

   // tick outside the window
   sequence s_miss1;
      i_first_pd_tick && !i_first_in_window;
   endsequence
   sequence s_miss2;
      i_second_pd_tick && !i_second_in_window;
   endsequence

   a_first_lock_drop: assert property (s_miss1 |-> ##2 !o_first_lock_indicator)
      else $error("first lock kept after miss");
   a_second_lock_drop: assert property (s_miss2 |-> ##2 !o_second_lock_indicator)
      else $error("second lock kept after miss");
   a_first_lock_rise: assert property ($rose(o_first_lock_indicator) |-> $past(hit1, 2))
      else $error("first lock rose without tick");
   a_dac_after_tick: assert property (o_dac_update |-> $past(i_first_pd_tick))
      else $error("dac update without tick");
   // fields move only after a latch rise
   a_field_after_latch: assert property ($changed(o_first_loop_ref_divider)
      || $changed(o_group_cfg) |-> $past(i_serial_latch_enable, 2)
      || $past(i_serial_latch_enable, 3) || $past(i_serial_latch_enable, 4))
      else $error("field changed without word");
   a_write_lock_holds: assert property (o_register_write_lock && $past(o_register_write_lock)
      |-> $stable(o_group_cfg) && $stable(o_first_loop_ref_divider))
      else $error("locked register changed");
   a_soft_reset_load: assert property ($rose(o_soft_reset_pending)
      |-> o_first_loop_ref_divider == 14'h0060 && o_second_loop_feedback_divider == 18'h00030)
      else $error("soft reset missed defaults");
   a_reset_defaults: assert property ($past(i_sys_rst) |-> o_readback_address == 5'h1F
      && o_first_loop_ref_divider == 14'h0060 && !o_second_lock_indicator)
      else $error("reset defaults wrong");
   a_group_bit_map: assert property (o_powerdown == o_group_cfg[1][17]
      && !o_group_cfg[2][17] && !o_group_cfg[0][30] && !o_group_cfg[5][30])
      else $error("group bit map wrong");
endmodule

// ### verification/tb_dual_pll_config_register_bank.sv
// self-checking bench for the loop configuration register bank
`timescale 1ns/1ps
module tb_dual_pll_config_register_bank;
   typedef struct packed { logic wr; logic [31:0] w; logic [31:0] m; } row_s;
   logic i_core_clk, i_sys_rst, i_ser_clk, i_ser_data, i_serial_latch_enable, o_readback_data;
   logic i_first_pd_tick, i_first_in_window, i_second_pd_tick, i_second_in_window;
   logic o_first_lock_indicator, o_second_lock_indicator, o_dac_update, o_soft_reset_pending;
   logic o_powerdown, o_reference_doubler_enable, o_second_loop_pump_polarity;
   logic o_second_loop_pump_tristate, o_fast_detector_allow, o_readback_latch_level;
   logic o_register_write_lock;
   logic [5:0][31:0] o_group_cfg;
   logic [2:0] o_first_loop_feedback_delay, o_first_loop_reference_delay;
   logic [2:0] o_oscillator_input_range, o_second_loop_prescaler;
   logic [1:0] o_first_loop_lock_window, o_second_loop_lock_window, o_input0_predivider;
   logic [1:0] o_input1_predivider, o_input2_predivider;
   logic [9:0] o_dac_divisor;
   logic [13:0] o_first_loop_lock_count, o_second_loop_lock_count, o_first_loop_ref_divider;
   logic [13:0] o_first_loop_feedback_divider;
   logic [11:0] o_second_loop_ref_divider;
   logic [17:0] o_calibration_feedback_copy, o_second_loop_feedback_divider;
   logic [4:0] o_readback_address;
   int bad_count = 0;
   int cmp_count = 0;
   logic [31:0] dac_n = 32'h0;
   logic [31:0] e;
   // reset rows, then writes; m keeps field bits
   row_s rows [17] = '{'{0,32'hD8,32'h77C0}, '{0,32'h01010019,32'hFFCFFFC0},
      '{0,32'hC08001A,32'hF00FFFE0}, '{0,32'h1000181B,32'h3FFFFC0},
      '{0,32'h40301C,32'hFFFFFFC0}, '{0,32'h780061D,32'h7FFFFE0},
      '{0,32'h200061E,32'h77FFFE0}, '{0,32'h1F001F,32'h3F0020},
      '{1,32'hFFFFFFF8,32'h77C0}, '{1,32'hFFFFFFF9,32'hFFCFFFC0},
      '{1,32'h2000003A,32'hF00FFFE0}, '{1,32'hD000001A,32'hF00FFFE0},
      '{1,32'h3FFFFDB,32'h3FFFFC0}, '{1,32'hFFF0005C,32'hFFFFFFC0},
      '{1,32'h77FFFFE,32'h77FFFE0}, '{1,32'h7FFFFD,32'h7FFFFE0},
      '{1,32'h3E001F,32'h3F0020}};

   dual_pll_config_register_bank dut_u (.*);
   host_serial_model host_u (.i_core_clk(i_core_clk), .o_ser_clk(i_ser_clk),
      .o_ser_data(i_ser_data), .o_latch(i_serial_latch_enable));

   // 200 MHz core clock
   initial
   begin
      i_core_clk = 1'b0;
      forever #2.5 i_core_clk = ~i_core_clk;
   end

   // count update pulses
   always @(posedge i_core_clk)
      if (o_dac_update === 1'b1)
         dac_n <= dac_n + 32'h1;

   // stored word rebuilt from field ports
   function automatic logic [31:0] got(input logic [4:0] a);
      case (a)
         5'h18: got = {17'h0, o_first_loop_feedback_delay, 1'b0, o_first_loop_reference_delay,
                       o_first_loop_lock_window, 6'h0};
         5'h19: got = {o_dac_divisor, 2'h0, o_first_loop_lock_count, 6'h0};
         5'h1A: got = {o_second_loop_lock_window, o_reference_doubler_enable,
                       o_second_loop_pump_polarity, 8'h0, o_second_loop_lock_count,
                       o_second_loop_pump_tristate, 5'h0};
         5'h1B: got = {6'h0, o_input2_predivider, o_input1_predivider, o_input0_predivider,
                       o_first_loop_ref_divider, 6'h0};
         5'h1C: got = {o_second_loop_ref_divider, o_first_loop_feedback_divider, 6'h0};
         5'h1D: got = {5'h0, o_oscillator_input_range, o_fast_detector_allow,
                       o_calibration_feedback_copy, 5'h0};
         5'h1E: got = {5'h0, o_second_loop_prescaler, 1'b0, o_second_loop_feedback_divider, 5'h0};
         default: got = {10'h0, o_readback_latch_level, o_readback_address, 10'h0,
                         o_register_write_lock, 5'h0};
      endcase
   endfunction

   task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
      cmp_count++;
      if (g !== x)
      begin
         bad_count++;
         $display("[ERR] %s expected %h seen %h", n, x, g);
      end
   endtask

   task automatic close_out();
      $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   // main sequence
   initial
   begin
      i_sys_rst = 1'b1;
      {i_first_pd_tick, i_first_in_window, i_second_pd_tick, i_second_in_window} = 4'h0;
      repeat (3) @(posedge i_core_clk);
      #1 i_sys_rst = 1'b0;
      for (int k = 0; k < 17; k++)
      begin
         if (rows[k].wr)
            host_u.send(rows[k].w);
         chk("field", rows[k].w & rows[k].m, got(rows[k].w[4:0]));
      end
      // lock counts 3, divisor 2
      host_u.send(32'h008000D9);
      host_u.send(32'h000000DA);
      for (int k = 1; k <= 4; k++)
      begin
         {i_first_in_window, i_second_in_window} = (k < 4) ? 2'h3 : 2'h0;
         {i_first_pd_tick, i_second_pd_tick} = 2'h3;
         @(posedge i_core_clk) #1 {i_first_pd_tick, i_second_pd_tick} = 2'h0;
         repeat (3) @(posedge i_core_clk);
         #1;
         chk("lock1", k == 3, o_first_lock_indicator);
         chk("lock2", k == 3, o_second_lock_indicator);
      end
      chk("dac", 32'h2, dac_n);
      // locked bank ignores an R28 write
      host_u.send(32'h0000003F);
      e = got(5'h1C);
      host_u.send(32'h0000101C);
      chk("locked", e, got(5'h1C));
      host_u.send(32'h0000001F);
      chk("unlock", 32'h0, o_register_write_lock);
      // all ones into groups 1..5
      for (int i = 1; i < 6; i++)
      begin
         host_u.send({27'h7FFFFFF, i[4:0]});
         e = 32'hBFFDFFE0 | (32'(i == 1) << 17) | (32'(i == 3 || i == 4) << 30);
         chk("group", e, o_group_cfg[i]);
      end
      host_u.send(32'h00020000);
      chk("srst", 32'h1, o_soft_reset_pending);
      chk("dflt", 32'h00001800, got(5'h1B) & 32'h03FFFFC0);
      chk("pdclr", 32'h0, o_powerdown);
      host_u.send(32'h0000001C);
      chk("srclr", 32'h0, o_soft_reset_pending);
      close_out();
   end
endmodule

bind dual_pll_config_register_bank dual_pll_config_register_bank_chk chk_u (.*);
